// ---- include/tpg_pkg.sv ----
// Package with register map, field layout and timing constants of the time pulse generator
`default_nettype none
package tpg_pkg;
	// Timebase
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned NS_PER_S        = 1_000_000_000;
	localparam int unsigned CLK_NS          = NS_PER_S / CLK_HZ;
	localparam int unsigned CYC_PER_US      = 1000 / CLK_NS;
	localparam int unsigned MIN_PHASE_NS    = 50;
	localparam int unsigned MIN_PHASE_CYC   = (MIN_PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PCT_FULL        = 100;
	localparam logic [31:0] CYC_PER_SEC     = 32'(CLK_HZ);
	// Register byte addresses
	localparam logic [5:0] ADR_CTRL         = 6'h00;
	localparam logic [5:0] ADR_INT_UNLK     = 6'h04;
	localparam logic [5:0] ADR_WID_UNLK     = 6'h08;
	localparam logic [5:0] ADR_INT_LOCK     = 6'h0c;
	localparam logic [5:0] ADR_WID_LOCK     = 6'h10;
	localparam logic [5:0] ADR_CABLE_DLY    = 6'h14;
	localparam logic [5:0] ADR_USER_DLY     = 6'h18;
	localparam logic [5:0] ADR_STATUS       = 6'h1c;
	localparam logic [5:0] ADR_NEXT_SEC     = 6'h20;
	localparam logic [5:0] ADR_NEXT_SUB     = 6'h24;
	// Control register fields
	localparam int unsigned CB_ENA          = 0;
	localparam int unsigned CB_FREQ_TYPE    = 1;
	localparam int unsigned CB_RATIO_TYPE   = 2;
	localparam int unsigned CB_USE_LOCKED   = 3;
	localparam int unsigned CB_FREQ_LOCK    = 4;
	localparam int unsigned CB_ALIGN        = 5;
	localparam int unsigned CB_POL          = 6;
	localparam int unsigned CB_GRID_LSB     = 8;
	localparam int unsigned GRID_W          = 3;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0141;
	localparam logic [31:0] INT_RESET       = 32'h000f_4240;
	localparam logic [31:0] WID_RESET       = 32'h0001_86a0;
	// Time grid codes
	localparam logic [2:0] GRID_UTC         = 3'h0;
	localparam logic [2:0] GRID_GPS         = 3'h1;
	localparam logic [2:0] GRID_BDS         = 3'h3;
	localparam logic [2:0] GRID_GAL         = 3'h4;
	localparam logic [2:0] GRID_NAVIC       = 3'h5;
	typedef enum logic [1:0] {TPG_IDLE, TPG_WAIT, TPG_HIGH, TPG_LOW} tpg_state_t;
endpackage : tpg_pkg
`default_nettype wire

// ---- include/tpg_div_if.sv ----
// Interface carrying operands and result of the sequential divider
`default_nettype none
interface tpg_div_if;
	logic        start;
	logic [63:0] num;
	logic [31:0] den;
	logic        busy;
	logic        done;
	logic [31:0] quo;
	modport master (output start, output num, output den, input busy, input done, input quo);
	modport slave  (input start, input num, input den, output busy, output done, output quo);
endinterface : tpg_div_if
`default_nettype wire

// ---- core/tpg_div.sv ----
// Sequential restoring divider, one quotient bit per clock
`default_nettype none
module tpg_div (
	input  wire logic   clk_i, // Clock
	input  wire logic   rst_i, // Synchronous reset
	tpg_div_if.slave    dv     // Operands and result
);
	logic [63:0] rem, next_rem;
	logic [63:0] q, next_q;
	logic [6:0]  cnt, next_cnt;
	logic        busy, next_busy;
	logic        done, next_done;
	logic [64:0] trial;

	always_comb begin
		next_rem  = rem;
		next_q    = q;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		trial     = '0;
		if (!busy && dv.start) begin
			next_rem  = '0;
			next_q    = dv.num;
			next_cnt  = 7'd64;
			next_busy = 1'b1;
		end else if (busy) begin
			trial = {rem, q[63]} - {33'd0, dv.den};
			if (!trial[64]) begin
				next_rem = trial[63:0];
				next_q   = {q[62:0], 1'b1};
			end else begin
				next_rem = {rem[62:0], q[63]};
				next_q   = {q[62:0], 1'b0};
			end
			next_cnt = cnt - 7'd1;
			if (cnt == 7'd1) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rem  <= '0;
			q    <= '0;
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			rem  <= next_rem;
			q    <= next_q;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign dv.busy = busy;
	assign dv.done = done;
	// Saturate when the quotient does not fit
	assign dv.quo  = (q[63:32] != 32'd0) ? 32'hffff_ffff : q[31:0];
endmodule : tpg_div
`default_nettype wire

// ---- core/tpg_top.sv ----
// Time pulse generator with Wishbone register file
// What this block does
// - Pulses appear only while the output enable bit is set; otherwise output idles.
// - Interval type bit selects frequency in Hz or period in microseconds.
// - Width type bit selects width in microseconds or duty ratio in percent.
// - Antenna cable delay shifts pulse edges.
// - User delay shifts pulse edges as well.
// - Unlocked pair is used when locked set disabled or time not valid.
// - With locked select set, switch to locked pair once time is valid.
// - Locked interval and width form an independent register pair.
// - Locked pair may disable pulsing or change duty while unlocked differs.
// - Frequency lock bit uses recovered satellite clock ticks instead of local clock.
// - Second alignment puts leading edges on top of second of the grid.
// - Rate persists regardless of lock; alignment holds only while locked.
// - Polarity bit set gives rising first edge, clear gives falling.
// - Grid codes 0 UTC, 1 GPS, 3 BeiDou, 4 Galileo, 5 NAVIC; reported too.
// - Width is clamped to at most one period.
// - Report gives time of the leading edge that ends each wait and time source in use.
`default_nettype none
module tpg_top (
	input  wire logic        clk_i,         // Clock, 100 MHz
	input  wire logic        rst_i,         // Synchronous reset, active high
	input  wire logic [31:0] wb_adr_i,      // Wishbone address
	input  wire logic [31:0] wb_dat_i,      // Wishbone write data
	input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects
	input  wire logic        wb_we_i,       // Wishbone write enable
	input  wire logic        wb_cyc_i,      // Wishbone cycle
	input  wire logic        wb_stb_i,      // Wishbone strobe
	output logic [31:0]      wb_dat_o,      // Wishbone read data
	output logic             wb_ack_o,      // Wishbone acknowledge
	output logic             wb_err_o,      // Wishbone error, unmapped address
	input  wire logic        time_valid_i,  // Receiver has valid time, asynchronous
	input  wire logic        sec_top_i,     // Top of second on grid, asynchronous pulse
	input  wire logic        gnss_tick_i,   // Recovered 100 MHz rate tick, asynchronous
	output logic             pps_output_pin // Time pulse output
);
	// Synchronisers
	logic [1:0] valid_s, top_s, tick_s;
	logic       top_d, tick_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_s <= '0;
			top_s   <= '0;
			tick_s  <= '0;
			top_d   <= 1'b0;
			tick_d  <= 1'b0;
		end else begin
			valid_s <= {valid_s[0], time_valid_i};
			top_s   <= {top_s[0], sec_top_i};
			tick_s  <= {tick_s[0], gnss_tick_i};
			top_d   <= top_s[1];
			tick_d  <= tick_s[1];
		end
	end
	wire logic locked   = valid_s[1];
	wire logic top_rise = top_s[1] & ~top_d;
	wire logic gtick    = tick_s[1] & ~tick_d;

	// Register file
	logic [31:0] ctrl, int_unlk, wid_unlk, int_lock, wid_lock, cable_dly, user_dly;
	logic [31:0] next_ctrl, next_int_unlk, next_wid_unlk, next_int_lock, next_wid_lock;
	logic [31:0] next_cable_dly, next_user_dly, next_dat;
	logic        next_ack, next_err, hit;
	logic [31:0] nxt_sec, nxt_sub;
	wire logic       use_lock  = ctrl[tpg_pkg::CB_USE_LOCKED] & locked;
	wire logic [2:0] grid      = ctrl[tpg_pkg::CB_GRID_LSB +: tpg_pkg::GRID_W];
	wire logic   req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire logic [5:0] adr = wb_adr_i[5:0];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	always_comb begin
		next_ctrl      = ctrl;
		next_int_unlk  = int_unlk;
		next_wid_unlk  = wid_unlk;
		next_int_lock  = int_lock;
		next_wid_lock  = wid_lock;
		next_cable_dly = cable_dly;
		next_user_dly  = user_dly;
		next_dat       = '0;
		hit            = 1'b1;
		case (adr)
			tpg_pkg::ADR_CTRL:      next_dat = ctrl;
			tpg_pkg::ADR_INT_UNLK:  next_dat = int_unlk;
			tpg_pkg::ADR_WID_UNLK:  next_dat = wid_unlk;
			tpg_pkg::ADR_INT_LOCK:  next_dat = int_lock;
			tpg_pkg::ADR_WID_LOCK:  next_dat = wid_lock;
			tpg_pkg::ADR_CABLE_DLY: next_dat = cable_dly;
			tpg_pkg::ADR_USER_DLY:  next_dat = user_dly;
			tpg_pkg::ADR_STATUS:    next_dat = {26'd0, grid, use_lock, locked, pps_output_pin};
			tpg_pkg::ADR_NEXT_SEC:  next_dat = nxt_sec;
			tpg_pkg::ADR_NEXT_SUB:  next_dat = nxt_sub;
			default:                hit = 1'b0;
		endcase
		if (wb_adr_i[31:6] != 26'd0) begin
			hit = 1'b0;
		end
		if (req && wb_we_i && hit) begin
			case (adr)
				tpg_pkg::ADR_CTRL:      next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_INT_UNLK:  next_int_unlk = merge(int_unlk, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_WID_UNLK:  next_wid_unlk = merge(wid_unlk, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_INT_LOCK:  next_int_lock = merge(int_lock, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_WID_LOCK:  next_wid_lock = merge(wid_lock, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_CABLE_DLY: next_cable_dly = merge(cable_dly, wb_dat_i, wb_sel_i);
				tpg_pkg::ADR_USER_DLY:  next_user_dly = merge(user_dly, wb_dat_i, wb_sel_i);
				default:                next_dat = '0;
			endcase
		end
		if (!req || wb_we_i || !hit) begin
			next_dat = '0;
		end
		next_ack = req & hit;
		next_err = req & ~hit;
	end

	// Effective settings
	wire logic       ena       = ctrl[tpg_pkg::CB_ENA];
	wire logic       freq_type = ctrl[tpg_pkg::CB_FREQ_TYPE];
	wire logic       ratio     = ctrl[tpg_pkg::CB_RATIO_TYPE];
	wire logic       freq_lock = ctrl[tpg_pkg::CB_FREQ_LOCK];
	wire logic       align     = ctrl[tpg_pkg::CB_ALIGN];
	wire logic       pol       = ctrl[tpg_pkg::CB_POL];
	wire logic [31:0] act_int  = use_lock ? int_lock : int_unlk;
	wire logic [31:0] act_wid  = use_lock ? wid_lock : wid_unlk;
	wire logic [31:0] dly_ns   = cable_dly + user_dly;

	// Pulse timing computation through divider
	tpg_div_if dv ();
	tpg_div u_div (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.dv    (dv)
	);
	typedef enum logic [1:0] {CP_PER, CP_WID, CP_DLY} tpg_cstep_t;
	tpg_cstep_t  cstep, next_cstep;
	logic [31:0] per_cyc, wid_cyc, dly_cyc, next_per_cyc, next_wid_cyc, next_dly_cyc;
	logic        cstart, next_cstart;

	always_comb begin
		next_cstep   = cstep;
		next_per_cyc = per_cyc;
		next_wid_cyc = wid_cyc;
		next_dly_cyc = dly_cyc;
		next_cstart  = 1'b0;
		if (!dv.busy && !cstart && !dv.done) begin
			next_cstart = 1'b1;
		end
		if (dv.done) begin
			case (cstep)
				CP_PER: begin
					next_per_cyc = freq_type ? dv.quo : act_int * 32'(tpg_pkg::CYC_PER_US);
					next_cstep = CP_WID;
				end
				CP_WID: begin
					next_wid_cyc = ratio ? dv.quo : act_wid * 32'(tpg_pkg::CYC_PER_US);
					if (next_wid_cyc > per_cyc) begin
						next_wid_cyc = per_cyc;
					end
					next_cstep = CP_DLY;
				end
				CP_DLY: begin
					next_dly_cyc = dv.quo;
					next_cstep   = CP_PER;
				end
				default: next_cstep = CP_PER;
			endcase
		end
	end

	always_comb begin
		dv.start = cstart;
		case (cstep)
			CP_PER: begin
				dv.num = 64'(tpg_pkg::CYC_PER_SEC);
				dv.den = (act_int == 32'd0) ? 32'd1 : act_int;
			end
			CP_WID: begin
				dv.num = 64'(per_cyc) * 64'(act_wid);
				dv.den = 32'(tpg_pkg::PCT_FULL);
			end
			default: begin
				dv.num = 64'(dly_ns);
				dv.den = 32'(tpg_pkg::CLK_NS);
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cstep   <= CP_PER;
			per_cyc <= '0;
			wid_cyc <= '0;
			dly_cyc <= '0;
			cstart  <= 1'b0;
		end else begin
			cstep   <= next_cstep;
			per_cyc <= next_per_cyc;
			wid_cyc <= next_wid_cyc;
			dly_cyc <= next_dly_cyc;
			cstart  <= next_cstart;
		end
	end

	// Pulse sequencer
	tpg_pkg::tpg_state_t st, next_st;
	logic [31:0] cnt, next_cnt, sec_cnt, next_sec_cnt, sub, next_sub;
	logic        pin_lvl, next_pin_lvl;
	logic [31:0] next_nxt_sec, next_nxt_sub;
	// Time advances on recovered ticks when locked to satellite frequency
	wire logic   adv = freq_lock ? gtick : 1'b1;
	wire logic   do_align = align & locked;

	always_comb begin
		next_st      = st;
		next_cnt     = cnt;
		next_pin_lvl = 1'b0;
		next_sec_cnt = sec_cnt;
		next_sub     = sub;
		next_nxt_sec = nxt_sec;
		next_nxt_sub = nxt_sub;
		if (adv) begin
			next_sub = (sub == tpg_pkg::CYC_PER_SEC - 32'd1) ? 32'd0 : sub + 32'd1;
			if (sub == tpg_pkg::CYC_PER_SEC - 32'd1) begin
				next_sec_cnt = sec_cnt + 32'd1;
			end
		end
		if (top_rise && do_align) begin
			next_sub     = '0;
			next_sec_cnt = sec_cnt + 32'd1;
		end
		case (st)
			tpg_pkg::TPG_IDLE: begin
				if (ena && per_cyc != 32'd0) begin
					next_st  = tpg_pkg::TPG_WAIT;
					next_cnt = dly_cyc;
				end
			end
			tpg_pkg::TPG_WAIT: begin
				if (do_align && top_rise) begin
					next_cnt = dly_cyc;
				end else if (adv) begin
					if (cnt == 32'd0) begin
						next_st  = (wid_cyc == 32'd0) ? tpg_pkg::TPG_LOW : tpg_pkg::TPG_HIGH;
						next_cnt = (wid_cyc == 32'd0) ? per_cyc - 32'd1 : wid_cyc - 32'd1;
						next_nxt_sec = sec_cnt;
						next_nxt_sub = sub;
					end else begin
						next_cnt = cnt - 32'd1;
					end
				end
			end
			tpg_pkg::TPG_HIGH: begin
				next_pin_lvl = 1'b1;
				if (adv) begin
					if (cnt == 32'd0 && wid_cyc >= per_cyc) begin
						next_cnt = wid_cyc - 32'd1;
					end else if (cnt == 32'd0) begin
						next_st      = tpg_pkg::TPG_LOW;
						next_pin_lvl = 1'b0;
						next_cnt     = per_cyc - wid_cyc - 32'd1;
					end else begin
						next_cnt = cnt - 32'd1;
					end
				end
				if (do_align && top_rise) begin
					next_st      = tpg_pkg::TPG_WAIT;
					next_pin_lvl = 1'b0;
					next_cnt     = dly_cyc;
				end
			end
			tpg_pkg::TPG_LOW: begin
				if (adv) begin
					if (cnt == 32'd0 || (cnt > per_cyc)) begin
						next_st  = (wid_cyc == 32'd0) ? tpg_pkg::TPG_LOW : tpg_pkg::TPG_HIGH;
						next_cnt = (wid_cyc == 32'd0) ? per_cyc - 32'd1 : wid_cyc - 32'd1;
						next_pin_lvl = (wid_cyc != 32'd0);
					end else begin
						next_cnt = cnt - 32'd1;
					end
				end
				if (do_align && top_rise) begin
					next_st  = tpg_pkg::TPG_WAIT;
					next_cnt = dly_cyc;
				end
			end
			default: next_st = tpg_pkg::TPG_IDLE;
		endcase
		if (st == tpg_pkg::TPG_WAIT && next_st == tpg_pkg::TPG_HIGH) begin
			next_pin_lvl = 1'b1;
		end
		if (!ena || per_cyc == 32'd0) begin
			next_st      = tpg_pkg::TPG_IDLE;
			next_pin_lvl = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl           <= tpg_pkg::CTRL_RESET;
			int_unlk       <= tpg_pkg::INT_RESET;
			wid_unlk       <= tpg_pkg::WID_RESET;
			int_lock       <= tpg_pkg::INT_RESET;
			wid_lock       <= tpg_pkg::WID_RESET;
			cable_dly      <= '0;
			user_dly       <= '0;
			wb_dat_o       <= '0;
			wb_ack_o       <= 1'b0;
			wb_err_o       <= 1'b0;
			st             <= tpg_pkg::TPG_IDLE;
			cnt            <= '0;
			sec_cnt        <= '0;
			sub            <= '0;
			pin_lvl        <= 1'b0;
			nxt_sec        <= '0;
			nxt_sub        <= '0;
			pps_output_pin <= 1'b0;
		end else begin
			ctrl           <= next_ctrl;
			int_unlk       <= next_int_unlk;
			wid_unlk       <= next_wid_unlk;
			int_lock       <= next_int_lock;
			wid_lock       <= next_wid_lock;
			cable_dly      <= next_cable_dly;
			user_dly       <= next_user_dly;
			wb_dat_o       <= next_dat;
			wb_ack_o       <= next_ack;
			wb_err_o       <= next_err;
			st             <= next_st;
			cnt            <= next_cnt;
			sec_cnt        <= next_sec_cnt;
			sub            <= next_sub;
			pin_lvl        <= next_pin_lvl;
			nxt_sec        <= next_nxt_sec;
			nxt_sub        <= next_nxt_sub;
			pps_output_pin <= ~(next_pin_lvl ^ pol);
		end
	end

endmodule : tpg_top
`default_nettype wire

// ---- bench/tpg_top_properties.sv ----
// Concurrent checks on the time pulse generator ports
`default_nettype none
module tpg_top_properties (
	input wire logic        clk_i,          // Clock
	input wire logic        rst_i,          // Reset
	input wire logic [31:0] wb_adr_i,       // Address
	input wire logic [31:0] wb_dat_i,       // Write data
	input wire logic [3:0]  wb_sel_i,       // Byte selects
	input wire logic        wb_we_i,        // Write enable
	input wire logic        wb_cyc_i,       // Cycle
	input wire logic        wb_stb_i,       // Strobe
	input wire logic [31:0] wb_dat_o,       // Read data
	input wire logic        wb_ack_o,       // Acknowledge
	input wire logic        wb_err_o,       // Error
	input wire logic        time_valid_i,   // Time valid
	input wire logic        pps_output_pin  // Pulse output
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sh_en;
	logic       sh_pol;
	logic       tv_q;
	logic [9:0] quiet;
	logic [3:0] tv_cnt;
	logic       ctrl_wr;
	assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i[5:0] == tpg_pkg::ADR_CTRL && wb_sel_i[0];
	// Shadow of enable and polarity, cycles since last control write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_en <= 1'b1;
			sh_pol <= 1'b1;
			quiet <= 10'h0;
			tv_q <= 1'b0;
			tv_cnt <= 4'h0;
		end else begin
			sh_en <= ctrl_wr ? wb_dat_i[tpg_pkg::CB_ENA] : sh_en;
			sh_pol <= ctrl_wr ? wb_dat_i[tpg_pkg::CB_POL] : sh_pol;
			quiet <= ctrl_wr ? 10'h0 : (quiet == 10'h3ff ? quiet : quiet + 10'h1);
			tv_q <= time_valid_i;
			tv_cnt <= (time_valid_i != tv_q) ? 4'h0 : (tv_cnt == 4'h8 ? tv_cnt : tv_cnt + 4'h1);
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	answer_pulse_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
		else $error("answer held longer than one cycle");
	answer_follows_a: assert property (s_taken |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered in one cycle");
	answer_needs_req_a: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("answer without request");
	err_unmapped_a: assert property (s_taken ##0 (wb_adr_i[31:6] != 26'h0) |=> wb_err_o)
		else $error("unmapped address not refused");
	mapped_ack_a: assert property (s_taken ##0 (wb_adr_i[31:6] == 26'h0) |=> wb_ack_o)
		else $error("mapped address not acknowledged");
	dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside acknowledge");
	reset_low_a: assert property (disable iff (1'b0) rst_i |=> !pps_output_pin)
		else $error("pulse output not low after reset");
	idle_when_off_a: assert property (quiet >= 10'd400 && !sh_en |-> pps_output_pin == !sh_pol)
		else $error("pulse output not idle while disabled");
	status_lock_a: assert property (wb_ack_o && !wb_we_i && tv_cnt == 4'h8 &&
		wb_adr_i[5:0] == tpg_pkg::ADR_STATUS |-> wb_dat_o[1] == time_valid_i)
		else $error("status lock bit wrong");
endmodule : tpg_top_properties
`default_nettype wire

// ---- bench/tpg_pps_rx.sv ----
// Timing equipment model measuring the pulse output phases
`default_nettype none
module tpg_pps_rx (
	input  wire logic        clk_i,     // Clock
	input  wire logic        rst_i,     // Reset
	input  wire logic        pin_i,     // Pulse input
	output logic [31:0]      now_o,     // Free cycle count
	output logic [31:0]      hi_len_o,  // Last high phase length
	output logic [31:0]      lo_len_o,  // Last low phase length
	output logic [31:0]      rises_o,   // Rising edges seen
	output logic [31:0]      rise_at_o  // Cycle of last rising edge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        pin_q;
	logic [31:0] run;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			now_o <= 32'h0;
			hi_len_o <= 32'h0;
			lo_len_o <= 32'h0;
			rises_o <= 32'h0;
			rise_at_o <= 32'h0;
			pin_q <= 1'b0;
			run <= 32'h0;
		end else begin
			now_o <= now_o + 32'h1;
			pin_q <= pin_i;
			run <= (pin_i != pin_q) ? 32'h1 : run + 32'h1;
			if (pin_i != pin_q && pin_q) begin
				hi_len_o <= run;
			end
			if (pin_i != pin_q && !pin_q) begin
				lo_len_o <= run;
				rises_o <= rises_o + 32'h1;
				rise_at_o <= now_o;
			end
		end
	end
endmodule : tpg_pps_rx
`default_nettype wire

// ---- bench/tb.sv ----
// Register level testbench for the time pulse generator
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
	logic        time_valid_i, sec_top_i, gnss_tick_i, pps_output_pin, tick_run, e;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q, t0, r0, r1, da, db;
	logic [31:0] now, hi_len, lo_len, rises, rise_at;
	logic [3:0]  wb_sel_i;
	logic [2:0]  grids [5];
	int          num_errors, checks, cyc_cnt;
	tpg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.time_valid_i(time_valid_i), .sec_top_i(sec_top_i), .gnss_tick_i(gnss_tick_i),
		.pps_output_pin(pps_output_pin));
	tpg_pps_rx u_rx (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pps_output_pin), .now_o(now),
		.hi_len_o(hi_len), .lo_len_o(lo_len), .rises_o(rises), .rise_at_o(rise_at));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		gnss_tick_i <= tick_run ? !gnss_tick_i : 1'b0;
		cyc_cnt++;
		if (cyc_cnt == 90000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
		checks++;
		if (^got === 1'bx || got > exp + tol || got + tol < exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [31:0] a, input logic we, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= s;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		chk(32'(n < 20), 32'h1, 0);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus({26'h0, a}, 1'b1, d, 4'hf);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		bus({26'h0, a}, 1'b0, 32'h0, 4'hf);
	endtask : rd
	task automatic cfg(input logic [31:0] c, input logic [31:0] iv, input logic [31:0] wv);
		wr(tpg_pkg::ADR_CTRL, c & 32'hffff_fffe);
		wr(tpg_pkg::ADR_INT_UNLK, iv);
		wr(tpg_pkg::ADR_WID_UNLK, wv);
		wr(tpg_pkg::ADR_CTRL, c);
	endtask : cfg
	task automatic phases(input int hi, input int lo);
		repeat (2500) @(posedge clk_i);
		chk(hi_len, hi, 2);
		chk(lo_len, lo, 2);
	endtask : phases
	task automatic frozen();
		r0 = rises;
		repeat (2000) @(posedge clk_i);
		chk(rises, r0, 0);
	endtask : frozen
	task automatic wait_rise(output logic [31:0] d);
		int n;
		n = 0;
		while (rises === r0 && n < 5000) begin
			@(posedge clk_i);
			n++;
		end
		d = rise_at - t0;
	endtask : wait_rise
	task automatic dly(input logic [31:0] c, input logic [31:0] u, output logic [31:0] d);
		wr(tpg_pkg::ADR_CTRL, 32'h0000_0140);
		wr(tpg_pkg::ADR_CABLE_DLY, c);
		wr(tpg_pkg::ADR_USER_DLY, u);
		repeat (300) @(posedge clk_i);
		wr(tpg_pkg::ADR_CTRL, 32'h0000_0141);
		t0 = now;
		r0 = rises;
		wait_rise(d);
	endtask : dly
	initial begin
		grids = '{tpg_pkg::GRID_UTC, tpg_pkg::GRID_GPS, tpg_pkg::GRID_BDS,
			tpg_pkg::GRID_GAL, tpg_pkg::GRID_NAVIC};
		{wb_we_i, wb_cyc_i, wb_stb_i, time_valid_i, sec_top_i, tick_run} = 6'h0;
		{wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(tpg_pkg::ADR_CTRL);
		chk(q, tpg_pkg::CTRL_RESET, 0);
		for (int i = 0; i < 4; i++) begin
			rd(6'(4 + 4 * i));
			chk(q, i[0] ? tpg_pkg::WID_RESET : tpg_pkg::INT_RESET, 0);
		end
		bus(32'h0000_0040, 1'b0, 32'h0, 4'hf);
		chk(32'(e), 32'h1, 0);
		$display("test reset done");
		cfg(32'h0000_0141, 32'd10, 32'd2);
		phases(200, 800);
		cfg(32'h0000_0101, 32'd10, 32'd2);
		phases(800, 200);
		cfg(32'h0000_0147, 32'd100000, 32'd25);
		phases(250, 750);
		cfg(32'h0000_0141, 32'd10, 32'd20);
		repeat (1500) @(posedge clk_i);
		frozen();
		chk(32'(pps_output_pin), 32'h1, 0);
		wr(tpg_pkg::ADR_CTRL, 32'h0000_0140);
		frozen();
		chk(32'(pps_output_pin), 32'h0, 0);
		$display("test shape done");
		wr(tpg_pkg::ADR_INT_LOCK, 32'd10);
		wr(tpg_pkg::ADR_WID_LOCK, 32'd5);
		cfg(32'h0000_0149, 32'd10, 32'd2);
		phases(200, 800);
		time_valid_i <= 1'b1;
		phases(500, 500);
		rd(tpg_pkg::ADR_STATUS);
		chk(q & 32'h0000_0006, 32'h0000_0006, 0);
		wr(tpg_pkg::ADR_INT_LOCK, 32'd0);
		frozen();
		time_valid_i <= 1'b0;
		phases(200, 800);
		$display("test locked done");
		dly(32'd0, 32'd0, da);
		dly(32'd15000, 32'd5000, db);
		chk(db - da, 32'd2000, 2);
		dly(32'd0, 32'd3000, db);
		chk(db - da, 32'd300, 2);
		dly(32'd0, 32'd0, db);
		$display("test delay done");
		cfg(32'h0000_0161, 32'd10, 32'd2);
		time_valid_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			repeat (100 + 337 * k) @(posedge clk_i);
			t0 = now;
			r0 = rises;
			sec_top_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			sec_top_i <= 1'b0;
			if (k == 0) wait_rise(da);
			else wait_rise(db);
		end
		chk(db, da, 2);
		$display("test align done");
		cfg(32'h0000_0151, 32'd10, 32'd2);
		repeat (300) @(posedge clk_i);
		frozen();
		r1 = rises;
		tick_run <= 1'b1;
		repeat (6000) @(posedge clk_i);
		chk(32'(rises != r1), 32'h1, 0);
		tick_run <= 1'b0;
		$display("test freq lock done");
		wr(tpg_pkg::ADR_CTRL, 32'h0000_0140);
		for (int i = 0; i < 5; i++) begin
			bus({26'h0, tpg_pkg::ADR_CTRL}, 1'b1, {21'h0, grids[i], 8'h0}, 4'h2);
			rd(tpg_pkg::ADR_CTRL);
			chk(q, {21'h0, grids[i], 8'h40}, 0);
			rd(tpg_pkg::ADR_STATUS);
			chk((q >> 3) & 32'h0000_0007, 32'(grids[i]), 0);
		end
		$display("test grid done");
		report_and_stop();
	end
endmodule : tb
bind tpg_top tpg_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.time_valid_i(time_valid_i), .pps_output_pin(pps_output_pin));
`default_nettype wire
